//--- rtl/sori_pkg.sv
// Contract
// - Outputs go off within the bank's response time after a field violation
// - Each bank holds one response time for all its field pairs
// - Each bank holds one start-up behaviour for all its field pairs
// - Automatic mode enables outputs at power-up once the field is free
// - Automatic restart re-enables outputs when the violated field clears
// - Start interlock mode keeps outputs off after supply return until reset
// - With start interlock, no enable after power-up without valid reset
// - Restart interlock keeps outputs off after field clears until reset
// - Restart interlock always includes start interlock
// - A valid reset press lasts at least 0.12 s and at most 4 s
// - Reference contour area is checked against the stored contour
// - Contour deviation above 200 mm switches the outputs off
// - Each bank holds one resolution: 30, 40, 50, 60, 70 or 150 mm
// - Each bank holds a maximum vehicle speed used for relative speed
package sori_pkg;
    localparam int CLOCK_HZ = 100000000;
    localparam int NUM_BANKS = 4;
    localparam int BANK_W = 2;
    // Press window in milliseconds
    localparam int PRESS_MIN_MS = 120;
    localparam int PRESS_MAX_MS = 4000;
    localparam int CYC_PER_MS = CLOCK_HZ / 1000;
    localparam int MS_W = 13;
    localparam logic [MS_W-1:0] PRESS_MIN_CNT = MS_W'(PRESS_MIN_MS);
    localparam logic [MS_W-1:0] PRESS_MAX_CNT = MS_W'(PRESS_MAX_MS);
    localparam int CONTOUR_TOL_MM = 200;
    localparam logic [15:0] CONTOUR_TOL = 16'(CONTOUR_TOL_MM);
    // Register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_EN = 8'h0c;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFF_BANK0 = 8'h20;
    localparam logic [7:0] OFF_TOL = 8'h30;
    // Bank word fields
    localparam int F_MODE_LSB = 0;
    localparam int F_RES_LSB = 4;
    localparam int F_RESP_LSB = 8;
    localparam int F_SPEED_LSB = 16;
    localparam int IRQ_W = 4;
    localparam int IRQ_VIOL = 0;
    localparam int IRQ_CONT = 1;
    localparam int IRQ_ON = 2;
    localparam int IRQ_BADPRESS = 3;
    localparam logic [31:0] BANK_RST = 32'h0064_0a32;
    localparam logic [15:0] TOL_RST = 16'h00c8;

    typedef enum logic [1:0] {
        SORI_MODE_AUTO,
        SORI_MODE_START_LOCK,
        SORI_MODE_FULL_LOCK
    } sori_mode_t;

    typedef enum logic [2:0] {
        SORI_RES_30, SORI_RES_40, SORI_RES_50,
        SORI_RES_60, SORI_RES_70, SORI_RES_150
    } sori_res_t;

    typedef struct packed {
        logic [15:0] max_vehicle_speed;
        logic [7:0] resp_ms;
        logic [0:0] pad_res;
        sori_res_t resolution;
        logic [1:0] pad_mode;
        sori_mode_t start_restart_lockout_mode;
    } sori_bank_t;

    typedef struct packed {
        logic field_violated;
        logic contour_present;
        logic [15:0] contour_dev_mm;
        logic [15:0] rel_speed;
    } sori_sense_t;
endpackage

//--- rtl/sori_press_timer.sv
`timescale 1ns/10ps
module sori_press_timer
    import sori_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Synchronised button and tick
    input wire logic pressed,
    input wire logic ms_tick,
    // Result
    output logic valid_release,
    output logic bad_release
);
    typedef struct packed {
        logic last;
        logic [MS_W-1:0] ms;
        logic good;
        logic bad;
    } sori_pt_state_t;

    sori_pt_state_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.good = 1'b0;
        next_st.bad = 1'b0;
        next_st.last = pressed;
        if (pressed) begin
            // Saturate just past the upper limit
            if (!st.last) begin
                next_st.ms = '0;
            end else if (ms_tick && st.ms <= PRESS_MAX_CNT) begin
                next_st.ms = st.ms + MS_W'(1);
            end
        end else if (st.last) begin
            if (st.ms >= PRESS_MIN_CNT && st.ms <= PRESS_MAX_CNT) begin
                next_st.good = 1'b1;
            end else begin
                next_st.bad = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign valid_release = st.good;
    assign bad_release = st.bad;
endmodule // sori_press_timer

//--- rtl/sori_interlock.sv
`timescale 1ns/10ps
module sori_interlock
    import sori_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensor inputs, from scan logic on this clock
    input wire sori_pkg::sori_sense_t sense,
    input wire logic [BANK_W-1:0] bank_sel,
    // Pins
    input wire logic supply_ok,
    input wire logic reset_button,
    // Outputs
    output logic safety_switching_outputs,
    output logic speed_exceeded,
    output logic irq
);
    import sori_pkg::*;

    typedef enum logic [1:0] {
        ST_START_LOCKED,
        ST_ON,
        ST_OFF_AUTO,
        ST_RESTART_LOCKED
    } sori_st_t;

    typedef struct packed {
        sori_st_t fsm;
        logic outs;
        logic [16:0] div;
        logic ms_tick;
        logic [7:0] viol_ms;
        logic [1:0] sup_sync;
        logic [1:0] btn_sync;
        logic enable;
        logic [NUM_BANKS-1:0][31:0] banks;
        logic [15:0] tol;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [31:0] rdata;
        logic slverr;
        logic spd;
    } sori_state_t;

    sori_state_t st, next_st;
    sori_bank_t bank;
    logic valid_release;
    logic bad_release;
    logic fault;
    logic field_free;
    logic [IRQ_W-1:0] ev;

    function automatic logic bank_addr(input logic [7:0] a,
                                       output logic [BANK_W-1:0] idx);
        idx = a[2+BANK_W-1:2];
        return a[7:4] == OFF_BANK0[7:4];
    endfunction

    sori_press_timer u_press (
        .clock(clock),
        .rst_b(rst_b),
        .pressed(st.btn_sync[1]),
        .ms_tick(st.ms_tick),
        .valid_release(valid_release),
        .bad_release(bad_release)
    );

    // Active bank steers mode, response time and speed; its resolution field is not used
    assign bank = sori_bank_t'(st.banks[bank_sel]);

    // Contour deviation beyond tolerance trips like a violation
    always_comb begin
        fault = sense.field_violated;
        if (sense.contour_present
            && sense.contour_dev_mm > st.tol) begin
            fault = 1'b1;
        end
    end
    assign field_free = !fault && st.sup_sync[1] && st.enable;

    always_comb begin
        logic [BANK_W-1:0] idx;
        logic hit;
        idx = '0;
        hit = 1'b0;
        next_st = st;
        ev = '0;
        next_st.sup_sync = {st.sup_sync[0], supply_ok};
        next_st.btn_sync = {st.btn_sync[0], reset_button};
        // Millisecond tick for press and response timing
        next_st.ms_tick = 1'b0;
        if (st.div == 17'(CYC_PER_MS - 1)) begin
            next_st.div = '0;
            next_st.ms_tick = 1'b1;
        end else begin
            next_st.div = st.div + 17'd1;
        end
        // Speed compare against the bank limit
        next_st.spd = sense.rel_speed > bank.max_vehicle_speed;

        case (st.fsm)
            ST_START_LOCKED: begin
                next_st.outs = 1'b0;
                if (bank.start_restart_lockout_mode == SORI_MODE_AUTO) begin
                    if (field_free) begin
                        next_st.fsm = ST_ON;
                    end
                end else if (field_free && valid_release) begin
                    next_st.fsm = ST_ON;
                end
            end
            ST_ON: begin
                next_st.outs = 1'b1;
                if (!st.sup_sync[1] || !st.enable) begin
                    next_st.fsm = ST_START_LOCKED;
                    next_st.outs = 1'b0;
                end else if (fault) begin
                    // Immediate cut is well inside any response time
                    next_st.outs = 1'b0;
                    ev[IRQ_VIOL] = 1'b1;
                    if (bank.start_restart_lockout_mode
                        == SORI_MODE_FULL_LOCK) begin
                        next_st.fsm = ST_RESTART_LOCKED;
                    end else begin
                        next_st.fsm = ST_OFF_AUTO;
                    end
                end
            end
            ST_OFF_AUTO: begin
                next_st.outs = 1'b0;
                if (!st.sup_sync[1] || !st.enable) begin
                    next_st.fsm = ST_START_LOCKED;
                end else if (!fault) begin
                    next_st.fsm = ST_ON;
                end
            end
            default: begin
                next_st.outs = 1'b0;
                if (!st.sup_sync[1] || !st.enable) begin
                    next_st.fsm = ST_START_LOCKED;
                end else if (field_free && valid_release) begin
                    next_st.fsm = ST_ON;
                end
            end
        endcase

        // Violation timer versus configured response time
        if (st.fsm == ST_ON && fault) begin
            if (st.ms_tick && st.viol_ms != 8'hff) begin
                next_st.viol_ms = st.viol_ms + 8'd1;
            end
        end else begin
            next_st.viol_ms = '0;
        end
        if (st.viol_ms >= bank.resp_ms) begin
            next_st.outs = 1'b0;
        end

        if (sense.contour_present && sense.contour_dev_mm > st.tol) begin
            ev[IRQ_CONT] = 1'b1;
        end
        ev[IRQ_ON] = !st.outs && next_st.outs;
        ev[IRQ_BADPRESS] = bad_release;

        // APB: zero wait state, answered in the access cycle
        next_st.slverr = 1'b0;
        if (psel && !penable) begin
            hit = 1'b1;
            next_st.rdata = '0;
            if (paddr == OFF_CTRL) begin
                next_st.rdata = {31'h0, st.enable};
            end else if (paddr == OFF_STATUS) begin
                next_st.rdata = {24'h0, st.spd, fault,
                                 st.btn_sync[1], st.sup_sync[1],
                                 st.outs, 1'b0, st.fsm};
            end else if (paddr == OFF_IRQ_STAT) begin
                next_st.rdata = {28'h0, st.irq_stat};
            end else if (paddr == OFF_IRQ_EN) begin
                next_st.rdata = {28'h0, st.irq_en};
            end else if (paddr == OFF_IRQ_CLR) begin
                next_st.rdata = '0;
            end else if (bank_addr(paddr, idx)) begin
                next_st.rdata = st.banks[idx];
            end else if (paddr == OFF_TOL) begin
                next_st.rdata = {16'h0, st.tol};
            end else begin
                hit = 1'b0;
            end
            next_st.slverr = !hit;
        end

        next_st.irq_stat = st.irq_stat;
        if (psel && penable && pwrite) begin
            if (paddr == OFF_CTRL) begin
                next_st.enable = pwdata[0];
            end else if (paddr == OFF_IRQ_EN) begin
                next_st.irq_en = pwdata[IRQ_W-1:0];
            end else if (paddr == OFF_IRQ_CLR) begin
                next_st.irq_stat = st.irq_stat & ~pwdata[IRQ_W-1:0];
            end else if (bank_addr(paddr, idx)) begin
                next_st.banks[idx] = pwdata;
            end else if (paddr == OFF_TOL) begin
                next_st.tol = pwdata[15:0];
            end
        end
        // Set wins over a clear in the same cycle
        next_st.irq_stat = next_st.irq_stat | ev;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st <= '0;
            st.fsm <= ST_START_LOCKED;
            st.enable <= 1'b1;
            st.tol <= TOL_RST;
            for (int i = 0; i < NUM_BANKS; i++) begin
                st.banks[i] <= BANK_RST;
            end
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && st.slverr;
    assign safety_switching_outputs = st.outs;
    assign speed_exceeded = st.spd;
    assign irq = |(st.irq_stat & st.irq_en);
endmodule // sori_interlock

//--- sim/sori_operator.sv
`timescale 1ns/10ps
module sori_operator (
    // Clock
    input wire logic clock,
    // Button contact
    output logic reset_button
);
    initial reset_button = 1'h0;
    // Hold is the caller's; full presses would cost millions of cycles
    task automatic press(input int cycles);
        @(posedge clock);
        reset_button <= 1'h1;
        repeat (cycles) @(posedge clock);
        reset_button <= 1'h0;
    endtask
endmodule // sori_operator

//--- sim/sori_interlock_asserts.sv
`timescale 1ns/10ps
module sori_interlock_asserts
    import sori_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Field and pins
    input wire sori_pkg::sori_sense_t sense,
    input wire logic supply_ok,
    input wire logic safety_switching_outputs
);
    logic cut;
    logic fault;
    assign cut = sense.contour_present && sense.contour_dev_mm > CONTOUR_TOL;
    assign fault = sense.field_violated || cut;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    ready_zero_wait_a: assert property (pready == (psel && penable))
        else $error("pready outside access phase");
    err_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("prdata moved without setup");
    field_cut_a: assert property (
        sense.field_violated |=> !safety_switching_outputs)
        else $error("outputs on after violation");
    contour_cut_a: assert property (
        cut |=> !safety_switching_outputs)
        else $error("outputs on after contour fault");
    rise_when_free_a: assert property (
        $rose(safety_switching_outputs) |-> !$past(fault))
        else $error("outputs rose during fault");
    supply_loss_off_a: assert property (
        !supply_ok [*4] |=> !safety_switching_outputs)
        else $error("outputs on without supply");
    rise_with_supply_a: assert property (
        $rose(safety_switching_outputs)
        |-> $past(supply_ok, 2) || $past(supply_ok, 3))
        else $error("outputs rose without supply");
endmodule // sori_interlock_asserts

bind sori_interlock sori_interlock_asserts chk (.clock(clock), .rst_b(rst_b),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .supply_ok(supply_ok),
    .safety_switching_outputs(safety_switching_outputs));

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
    import sori_pkg::*;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, out, speed_exceeded, irq, reset_button;
    logic [2:0] flags;
    sori_sense_t sense = '0;
    logic [BANK_W-1:0] bank_sel = '0;
    logic supply_ok = 1'h1;
    logic [64:0] notes[$];
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 93395;
    assign flags = {speed_exceeded, irq, out};
    always #5 clock = ~clock;
    sori_interlock uut (.clock(clock), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
        .bank_sel(bank_sel), .supply_ok(supply_ok), .irq(irq),
        .reset_button(reset_button), .safety_switching_outputs(out),
        .speed_exceeded(speed_exceeded));
    sori_operator op (.clock(clock), .reset_button(reset_button));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            report_and_stop();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        // Idle edge, so a following call never rewrites psel in one step
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        // Addresses past the tolerance register are unmapped
        notes.push_back({a > OFF_TOL, m, e});
        apb(1'h0, a, 32'h0);
    endtask
    // Outputs are sampled mid-cycle so registered updates have landed
    task automatic probe(input int w, input logic v);
        @(negedge clock);
        check(32'(flags[w]), 32'(v));
        @(posedge clock);
    endtask
    task automatic wait_out(input logic v, input int lim);
        int n;
        n = 0;
        @(negedge clock);
        while (out !== v && n < lim) begin
            @(negedge clock);
            n++;
        end
        check(32'(out), 32'(v));
        @(posedge clock);
    endtask
    always @(posedge clock) begin : watch
        logic [64:0] nt;
        if (psel && penable && pready === 1'h1 && !pwrite
            && notes.size() > 0) begin
            nt = notes.pop_front();
            check(prdata & nt[63:32], nt[31:0]);
            check(32'(pslverr), 32'(nt[64]));
        end
    end
    initial begin
        repeat (50000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
        @(posedge clock);
        rd(OFF_BANK0, 32'hffffffff, BANK_RST);
        rd(OFF_TOL, 32'hffff, 32'(TOL_RST));
        rd(OFF_CTRL, 32'h1, 32'h1);
        rd(8'h40, 32'hffffffff, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'h1, OFF_BANK0 + 8'hc, 32'h00960a01 | 32'(i << 4));
            rd(OFF_BANK0 + 8'hc, 32'hffffffff,
               32'h00960a01 | 32'(i << 4));
        end
        apb(1'h1, OFF_BANK0 + 8'hc, 32'h00960a50);
        apb(1'h1, OFF_BANK0, 32'h00640a30);
        wait_out(1'h1, 40);
        rd(OFF_IRQ_STAT, 32'h4, 32'h4);
        apb(1'h1, OFF_IRQ_EN, 32'hf);
        probe(1, 1'h1);
        apb(1'h1, OFF_IRQ_CLR, 32'hf);
        probe(1, 1'h0);
        sense.field_violated <= 1'h1;
        wait_out(1'h0, 2);
        probe(1, 1'h1);
        sense.field_violated <= 1'h0;
        wait_out(1'h1, 40);
        sense.contour_present <= 1'h1;
        sense.contour_dev_mm <= 16'(CONTOUR_TOL_MM);
        repeat (5) @(posedge clock);
        wait_out(1'h1, 0);
        sense.contour_dev_mm <= 16'(CONTOUR_TOL_MM + 1);
        wait_out(1'h0, 2);
        rd(OFF_IRQ_STAT, 32'h2, 32'h2);
        sense.contour_present <= 1'h0;
        wait_out(1'h1, 40);
        sense.rel_speed <= 16'(101 + $unsigned($random(seed)) % 49);
        repeat (2) @(posedge clock);
        probe(2, 1'h1);
        bank_sel <= 2'h3;
        repeat (2) @(posedge clock);
        probe(2, 1'h0);
        bank_sel <= 2'h0;
        sense.rel_speed <= 16'($unsigned($random(seed)) % 100);
        repeat (2) @(posedge clock);
        probe(2, 1'h0);
        apb(1'h1, OFF_BANK0, BANK_RST);
        sense.field_violated <= 1'h1;
        wait_out(1'h0, 2);
        sense.field_violated <= 1'h0;
        repeat (30) @(posedge clock);
        wait_out(1'h0, 0);
        op.press(10);
        repeat (5) @(posedge clock);
        rd(OFF_IRQ_STAT, 32'h8, 32'h8);
        wait_out(1'h0, 0);
        apb(1'h1, OFF_BANK0, 32'h00640a31);
        supply_ok <= 1'h0;
        repeat (6) @(posedge clock);
        supply_ok <= 1'h1;
        repeat (30) @(posedge clock);
        wait_out(1'h0, 0);
        apb(1'h1, OFF_BANK0, 32'h00640a30);
        wait_out(1'h1, 40);
        report_and_stop();
    end
endmodule // tb
